/* File: hw/link_port_glue.sv */
// Glue logic for the host-link transceiver board on the processor I/O bus.
`timescale 1ns/1ps
module link_port_glue
    import link_glue_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ce, // Clock enable; low freezes the core_clk side of the block.
    input wire io_req_s io, // Processor I/O request.
    output logic [7:0] io_rdata, // Read data, registered.
    output logic io_rvalid, // One-cycle read data valid.
    output logic irq2_req, // Level 2 interrupt request.
    output xcvr_bus_s xcvr, // Strobes and data to the transceiver.
    input wire logic [7:0] xcvr_rdata, // Data driven by the transceiver.
    input wire xcvr_pins_s xcvr_pins, // Transceiver pins and mode strap.
    input wire logic link_clk, // Clock from the modem.
    input wire modem_lines_s modem_pins, // Modem control lines.
    output logic bitclk_out, // Generated serial bit clock.
    output logic bitclk_int_sel // High selects the generated bit clock.
);
    io_req_s req_r;
    xcvr_pins_s pins_s1_r;
    xcvr_pins_s pins_s2_r;
    modem_lines_s modem_live;
    modem_lines_s snap_r;
    wr_phase_e phase_r;
    logic [7:0] io_rdata_r, rd_mux, irq_word, div_cnt_r;
    logic io_rvalid_r, oie_r, modem_int_r, any_src_d_r, irq_r;
    logic async_mode_r, bitclk_r, gen_sel_r;
    logic hit_data, hit_cmd, hit_modem, hit_irq, hit_cfg, hit_xcvr;
    logic read_modem, read_irq, write_irq, write_cmd;
    logic src_rx, src_tx, src_sync, any_src, modem_moved, async_active;
    logic [CFG_IDX_W-1:0] cfg_idx;

    // Modem lines cross in from the link clock domain.
    modem_line_xfer u_xfer (
        .link_clk(link_clk),
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .pins(modem_pins),
        .lines(modem_live)
    );

    // Transceiver pins and the strap come from outside; synchronise them.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
        end else if (ce) begin
            pins_s1_r <= xcvr_pins;
            pins_s2_r <= pins_s1_r;
        end
    end

    // Request stage: every access is acted on in the cycle after it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_r <= '0;
        end else if (ce) begin
            req_r <= io;
        end
    end

    // Device code decode of the staged request.
    assign hit_data = req_r.code == DC_DATA;
    assign hit_cmd = req_r.code == DC_CMD;
    assign hit_modem = req_r.code == DC_MODEM;
    assign hit_irq = req_r.code == DC_IRQ;
    assign hit_cfg = req_r.code >= DC_CFG_LO && req_r.code <= DC_CFG_HI;
    assign hit_xcvr = hit_data | hit_cmd;
    assign read_modem = ce & req_r.rd & hit_modem;
    assign read_irq = ce & req_r.rd & hit_irq;
    assign write_irq = ce & req_r.wr & hit_irq;
    assign write_cmd = ce & req_r.wr & hit_cmd;
    assign cfg_idx = req_r.code[CFG_IDX_W-1:0];

    // Transceiver strobes; the control/data select picks code 41 over 40.
    assign xcvr.cs_n = ~(hit_xcvr & (req_r.rd | req_r.wr));
    assign xcvr.rd_n = ~(hit_xcvr & req_r.rd);
    assign xcvr.wr_n = ~(hit_xcvr & req_r.wr);
    assign xcvr.ctrl = hit_cmd;
    assign xcvr.wdata = req_r.wdata;

    // Output interrupt enable follows bit 0 of each write to code 47.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oie_r <= 1'b0;
        end else if (write_irq) begin
            oie_r <= req_r.wdata[OIE_BIT];
        end
    end

    // Snapshot of the modem lines taken on each modem status read.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            snap_r <= '0;
        end else if (read_modem) begin
            snap_r <= modem_live;
        end
    end

    // The read reports the live lines and moves the snapshot to them, so
    // the difference seen in that cycle is consumed by the read itself.
    assign modem_moved = modem_live != snap_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            modem_int_r <= 1'b1;
        end else if (read_modem) begin
            modem_int_r <= 1'b0;
        end else if (ce && modem_moved) begin
            modem_int_r <= 1'b1;
        end
    end

    // Interrupt sources and the status word.
    assign src_rx = pins_s2_r.rx_char_ready;
    assign src_tx = pins_s2_r.tx_holding_ready & oie_r;
    assign src_sync = pins_s2_r.sync_found_pin;
    assign any_src = src_rx | src_tx | src_sync | modem_int_r;
    assign irq_word = {STAT_PAD, modem_int_r, src_sync, src_tx, src_rx};

    // Previous combined source level, for rise detection.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            any_src_d_r <= 1'b0;
        end else if (ce) begin
            any_src_d_r <= any_src;
        end
    end

    // Request set on a rise of the sources, cleared by a status read;
    // a rise in the clearing cycle wins. Sources added while another stays active never retrigger.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else if (ce && any_src && !any_src_d_r) begin
            irq_r <= 1'b1;
        end else if (read_irq) begin
            irq_r <= 1'b0;
        end
    end

    // Read data selection for the staged request.
    always_comb begin
        rd_mux = IDLE_BUS;
        if (hit_xcvr) begin
            rd_mux = xcvr_rdata;
        end else if (hit_modem) begin
            rd_mux = {MODEM_PAD, modem_live};
        end else if (hit_irq) begin
            rd_mux = irq_word;
        end else if (hit_cfg) begin
            rd_mux = CFG_IMAGE[cfg_idx];
        end
    end

    // Read data register and its valid pulse.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_rdata_r <= IDLE_BUS;
            io_rvalid_r <= 1'b0;
        end else if (ce) begin
            io_rvalid_r <= req_r.rd;
            if (req_r.rd) begin
                io_rdata_r <= rd_mux;
            end
        end
    end

    // Track which control word the transceiver takes next on code 41.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_r <= W_MODE;
            async_mode_r <= 1'b0;
        end else if (write_cmd) begin
            unique case (phase_r)
                W_MODE: begin
                    async_mode_r <= |(req_r.wdata & MODE_BAUD_MASK);
                    if (|(req_r.wdata & MODE_BAUD_MASK)) begin
                        phase_r <= W_CMD;
                    end else if (|(req_r.wdata & MODE_SINGLE_SYNC_MASK)) begin
                        phase_r <= W_SYNC2; // One sync character only.
                    end else begin
                        phase_r <= W_SYNC1;
                    end
                end
                W_SYNC1: begin
                    phase_r <= W_SYNC2;
                end
                W_SYNC2: begin
                    phase_r <= W_CMD;
                end
                W_CMD: begin
                    if (|(req_r.wdata & CMD_IRESET_MASK)) begin
                        phase_r <= W_MODE;
                    end
                end
            endcase
        end
    end

    // The board makes its own bit clock only with strap and async mode.
    assign async_active = pins_s2_r.async_strap & async_mode_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= '0;
            bitclk_r <= 1'b0;
            gen_sel_r <= 1'b0;
        end else if (ce) begin
            gen_sel_r <= async_active;
            if (!async_active) begin
                div_cnt_r <= '0;
                bitclk_r <= 1'b0;
            end else if (div_cnt_r == BITCLK_HALF - 8'h01) begin
                div_cnt_r <= '0;
                bitclk_r <= ~bitclk_r;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    assign io_rdata = io_rdata_r;
    assign io_rvalid = io_rvalid_r;
    assign irq2_req = irq_r;
    assign bitclk_out = bitclk_r;
    assign bitclk_int_sel = gen_sel_r;

    // Checks on the core clock domain.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_oie_wr;
        ce && io.wr && io.code == DC_IRQ ##1 ce;
    endsequence
    sequence s_data_wr;
        ce && io.wr && io.code == DC_DATA;
    endsequence

    property p_cfg_read;
        ce && req_r.rd && hit_cfg
            |=> io_rvalid_r && io_rdata_r == CFG_IMAGE[$past(cfg_idx)];
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("configuration read returned wrong byte");

    property p_por_irq;
        !rst && $past(rst) && ce |=> irq2_req && modem_int_r;
    endproperty
    a_por_irq: assert property (p_por_irq)
        else $error("no level 2 request after reset");

    property p_modem_change;
        ce && modem_moved && !req_r.rd |=> modem_int_r;
    endproperty
    a_modem_change: assert property (p_modem_change)
        else $error("modem change did not raise interrupt");

    property p_sync_src;
        read_irq |=> io_rdata_r[IRQ_SYNC_BIT] == $past(src_sync);
    endproperty
    a_sync_src: assert property (p_sync_src)
        else $error("sync detected bit wrong");

    property p_tx_gate;
        read_irq && !oie_r |=> !io_rdata_r[IRQ_TX_BIT]
            && io_rdata_r[IRQ_RX_BIT] == $past(pins_s2_r.rx_char_ready);
    endproperty
    a_tx_gate: assert property (p_tx_gate)
        else $error("transmit source not gated by enable");

    property p_oie_set;
        s_oie_wr |=> oie_r == $past(io.wdata[OIE_BIT], 2);
    endproperty
    a_oie_set: assert property (p_oie_set)
        else $error("output interrupt enable not loaded");

    property p_irq_word;
        read_irq |=> io_rdata_r[7:4] == STAT_PAD
            && io_rdata_r[IRQ_MODEM_BIT] == $past(modem_int_r);
    endproperty
    a_irq_word: assert property (p_irq_word)
        else $error("interrupt status word malformed");

    property p_no_retrigger;
        ce && any_src_d_r && !irq_r |=> !irq2_req;
    endproperty
    a_no_retrigger: assert property (p_no_retrigger)
        else $error("request raised without a source rise");

    property p_modem_word;
        read_modem |=> io_rdata_r == {MODEM_PAD, $past(modem_live)}
            && snap_r == $past(modem_live) && !modem_int_r;
    endproperty
    a_modem_word: assert property (p_modem_word)
        else $error("modem status read wrong");

    property p_data_strobe;
        s_data_wr |=> !xcvr.cs_n && !xcvr.wr_n && !xcvr.ctrl && xcvr.rd_n;
    endproperty
    a_data_strobe: assert property (p_data_strobe)
        else $error("transceiver data write not strobed");

    property p_bitclk_gate;
        bitclk_r |-> gen_sel_r;
    endproperty
    a_bitclk_gate: assert property (p_bitclk_gate)
        else $error("bit clock runs outside async mode");

    property p_rise_sets;
        ce && any_src && !any_src_d_r |=> irq2_req;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("source rise did not raise request");
endmodule

/* File: hw/link_glue_pkg.sv */
// Shared constants and types for the host-link glue block.
package link_glue_pkg;
    // Device codes on the processor I/O bus.
    localparam logic [7:0] DC_DATA = 8'h40;
    localparam logic [7:0] DC_CMD = 8'h41;
    localparam logic [7:0] DC_MODEM = 8'h46;
    localparam logic [7:0] DC_IRQ = 8'h47;
    localparam logic [7:0] DC_CFG_LO = 8'h60;
    localparam logic [7:0] DC_CFG_HI = 8'h7f;
    // Value returned for a code that nothing on this board answers.
    localparam logic [7:0] IDLE_BUS = 8'hff;

    // Interrupt status word layout; the upper nibble reads as ones.
    localparam int IRQ_RX_BIT = 0;
    localparam int IRQ_TX_BIT = 1;
    localparam int IRQ_SYNC_BIT = 2;
    localparam int IRQ_MODEM_BIT = 3;
    localparam logic [3:0] STAT_PAD = 4'hf;
    // Modem status word pad; bits 7:6 read as ones.
    localparam logic [1:0] MODEM_PAD = 2'h3;
    // Output interrupt enable is data bit 0 of a write to code 47.
    localparam int OIE_BIT = 0;

    // Transceiver control word fields watched on writes to code 41.
    localparam logic [7:0] MODE_BAUD_MASK = 8'h03;
    localparam logic [7:0] MODE_SINGLE_SYNC_MASK = 8'h80;
    localparam logic [7:0] CMD_IRESET_MASK = 8'h40;

    // Half period of the generated bit clock in core_clk cycles.
    localparam logic [7:0] BITCLK_HALF = 8'h1a;

    // Configuration image, fixed at installation time.
    localparam int CFG_IDX_W = 5;
    localparam logic [31:0][7:0] CFG_IMAGE = '0;

    // Modem lines, active high, in status word order 5..0.
    typedef struct packed {
        logic ring_indicator_line;
        logic carrier;
        logic clear_to_send;
        logic request_to_send;
        logic set_ready;
        logic terminal_ready;
    } modem_lines_s;

    // One processor I/O request; rd and wr are one-cycle strobes.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] code;
        logic [7:0] wdata;
    } io_req_s;

    // Strobes and data towards the transceiver.
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic ctrl;
        logic [7:0] wdata;
    } xcvr_bus_s;

    // Transceiver status pins and the asynchronous mode strap.
    typedef struct packed {
        logic async_strap;
        logic sync_found_pin;
        logic tx_holding_ready;
        logic rx_char_ready;
    } xcvr_pins_s;

    // Which kind of control word the transceiver expects next.
    typedef enum logic [1:0] {
        W_MODE = 2'h0,
        W_SYNC1 = 2'h1,
        W_SYNC2 = 2'h3,
        W_CMD = 2'h2
    } wr_phase_e;
endpackage

/* File: hw/modem_line_xfer.sv */
// Modem line sampler on the link clock with a toggle handshake to core_clk.
`timescale 1ns/1ps
module modem_line_xfer
    import link_glue_pkg::*;
(
    input wire logic link_clk, // Modem side clock.
    input wire logic core_clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ce, // Core side clock enable.
    input wire modem_lines_s pins, // Raw modem control lines.
    output modem_lines_s lines // Lines as seen on core_clk.
);
    modem_lines_s pin_s1_r;
    modem_lines_s pin_s2_r;
    modem_lines_s word_r;
    logic req_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic req_s1_r;
    logic req_s2_r;
    logic ack_r;

    // Two-stage synchroniser for the modem pins.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= pins;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Acknowledge toggle brought back to the link side.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // Launch a new word only when idle, so word_r is stable in flight.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            word_r <= '0;
            req_r <= 1'b0;
        end else if (req_r == ack_s2_r && pin_s2_r != word_r) begin
            word_r <= pin_s2_r;
            req_r <= ~req_r;
        end
    end

    // Core side takes the word once the request toggle has settled.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_r <= 1'b0;
            lines <= '0;
        end else if (ce) begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            if (req_s2_r != ack_r) begin
                lines <= word_r;
                ack_r <= req_s2_r;
            end
        end
    end

    // The word in flight must not move before it is acknowledged.
    property p_word_held;
        @(posedge link_clk) disable iff (rst)
        (req_r != ack_s2_r) |=> $stable(word_r);
    endproperty
    a_word_held: assert property (p_word_held)
        else $error("modem word changed while in flight");
endmodule

/* File: bench/modem_far_end.sv */
// Far-side model: modem control lines and the transceiver's read answer.
`timescale 1ns/1ps
module modem_far_end
    import link_glue_pkg::*;
#(
    parameter logic [7:0] ANSWER = 8'h85
)
(
    input wire logic link_clk, // Modem clock.
    input wire modem_lines_s want, // Line levels asked for by the bench.
    input wire xcvr_bus_s xcvr, // Strobes from the glue.
    output modem_lines_s lines, // Lines towards the glue.
    output logic [7:0] rdata // Transceiver read data.
);
    // Modem lines change only just after a link clock edge.
    initial begin
        lines = '0;
        forever @(posedge link_clk) begin
            lines <= want;
        end
    end

    // Data is driven only while selected for a read, else inverted.
    always_comb begin
        if (!xcvr.cs_n && !xcvr.rd_n) begin
            rdata = ANSWER;
        end else begin
            rdata = ~ANSWER;
        end
    end
endmodule

/* File: bench/test_sync_link_port_interrupt_glue.sv */
// Self-checking bench for the host-link glue block.
`timescale 1ns/1ps
module test_sync_link_port_interrupt_glue;
    import link_glue_pkg::*;
    localparam logic [7:0] XCVR_ANS = 8'h85;
    logic core_clk, rst, ce, link_clk;
    io_req_s io;
    logic [7:0] io_rdata, xcvr_rdata;
    logic io_rvalid, irq2_req, bitclk_out, bitclk_int_sel;
    xcvr_bus_s xcvr;
    xcvr_pins_s xcvr_pins;
    modem_lines_s modem_pins, modem_want;
    int mismatches, compares;

    link_port_glue dut_u (
        .core_clk(core_clk), .rst(rst), .ce(ce), .io(io),
        .io_rdata(io_rdata), .io_rvalid(io_rvalid), .irq2_req(irq2_req),
        .xcvr(xcvr), .xcvr_rdata(xcvr_rdata), .xcvr_pins(xcvr_pins),
        .link_clk(link_clk), .modem_pins(modem_pins),
        .bitclk_out(bitclk_out), .bitclk_int_sel(bitclk_int_sel)
    );
    modem_far_end #(.ANSWER(XCVR_ANS)) far_u (
        .link_clk(link_clk), .want(modem_want), .xcvr(xcvr),
        .lines(modem_pins), .rdata(xcvr_rdata)
    );

    // Core clock at 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Link clock, 64 ns period, offset in phase.
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end

    task test_done;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One write; returns in the cycle where the transceiver strobes show.
    task io_wr(input logic [7:0] code, input logic [7:0] data);
        @(negedge core_clk);
        io = {2'b01, code, data};
        @(negedge core_clk);
        io = '0;
    endtask

    // One read, judged against the expected byte.
    task rd_chk(input logic [7:0] code, input logic [7:0] exp);
        int i;
        @(negedge core_clk);
        io = {2'b10, code, 8'h00};
        @(negedge core_clk);
        io = '0;
        for (i = 0; i < 4 && io_rvalid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk({7'h00, io_rvalid}, 8'h01);
        chk(io_rdata, exp);
    endtask

    // Waits a bounded time for the level 2 request.
    task wait_irq;
        int i;
        for (i = 0; i < 60 && irq2_req !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk({7'h00, irq2_req}, 8'h01);
    endtask

    task t_power_on;
        chk(io_rdata, 8'hff);
        chk({6'h00, irq2_req, bitclk_int_sel}, 8'h00);
        chk({7'h00, xcvr.cs_n}, 8'h01);
        @(negedge core_clk);
        rst = 1'b0;
        cyc(2);
        chk({7'h00, irq2_req}, 8'h01);
        rd_chk(DC_IRQ, 8'hf8);
        chk({7'h00, irq2_req}, 8'h00);
        rd_chk(DC_MODEM, 8'hc0);
        rd_chk(DC_IRQ, 8'hf0);
        $display("t_power_on done");
    endtask

    task t_config;
        int i;
        for (i = 0; i < 32; i++) begin
            rd_chk(DC_CFG_LO + 8'(i), CFG_IMAGE[i]);
        end
        rd_chk(8'h50, IDLE_BUS);
        io_wr(DC_CFG_LO, 8'h5a);
        rd_chk(DC_CFG_LO, CFG_IMAGE[0]);
        $display("t_config done");
    endtask

    task t_tx_enable;
        xcvr_pins.tx_holding_ready = 1'b1;
        cyc(6);
        chk({7'h00, irq2_req}, 8'h00);
        rd_chk(DC_IRQ, 8'hf0);
        io_wr(DC_IRQ, 8'hfe);
        cyc(6);
        chk({7'h00, irq2_req}, 8'h00);
        io_wr(DC_IRQ, 8'h01);
        wait_irq();
        rd_chk(DC_IRQ, 8'hf2);
        io_wr(DC_IRQ, 8'h00);
        cyc(2);
        rd_chk(DC_IRQ, 8'hf0);
        xcvr_pins.tx_holding_ready = 1'b0;
        $display("t_tx_enable done");
    endtask

    task t_rx_sync;
        xcvr_pins.rx_char_ready = 1'b1;
        wait_irq();
        rd_chk(DC_IRQ, 8'hf1);
        chk({7'h00, irq2_req}, 8'h00);
        xcvr_pins.sync_found_pin = 1'b1;
        cyc(6);
        chk({7'h00, irq2_req}, 8'h00);
        rd_chk(DC_IRQ, 8'hf5);
        xcvr_pins.rx_char_ready = 1'b0;
        xcvr_pins.sync_found_pin = 1'b0;
        cyc(4);
        rd_chk(DC_IRQ, 8'hf0);
        $display("t_rx_sync done");
    endtask

    task t_modem;
        modem_want = 6'h2a;
        wait_irq();
        rd_chk(DC_IRQ, 8'hf8);
        rd_chk(DC_MODEM, 8'hea);
        rd_chk(DC_IRQ, 8'hf0);
        modem_want = 6'h00;
        wait_irq();
        rd_chk(DC_MODEM, 8'hc0);
        rd_chk(DC_IRQ, 8'hf0);
        $display("t_modem done");
    endtask

    task t_xcvr;
        int i;
        logic b;
        xcvr_pins.async_strap = 1'b1;
        io_wr(DC_CMD, 8'h4e);
        chk({4'h0, xcvr.cs_n, xcvr.wr_n, xcvr.rd_n, xcvr.ctrl}, 8'h03);
        chk(xcvr.wdata, 8'h4e);
        io_wr(DC_DATA, 8'h5a);
        chk({4'h0, xcvr.cs_n, xcvr.wr_n, xcvr.rd_n, xcvr.ctrl}, 8'h02);
        chk(xcvr.wdata, 8'h5a);
        cyc(1);
        chk({7'h00, xcvr.cs_n}, 8'h01);
        rd_chk(DC_CMD, XCVR_ANS);
        rd_chk(DC_DATA, XCVR_ANS);
        for (i = 0; i < 10 && bitclk_int_sel !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk({7'h00, bitclk_int_sel}, 8'h01);
        b = bitclk_out;
        for (i = 0; i < 60 && bitclk_out === b; i++) begin
            @(negedge core_clk);
        end
        chk({7'h00, bitclk_out}, {7'h00, ~b});
        // Internal reset, then a sync mode word asking for one sync char.
        io_wr(DC_CMD, 8'h40);
        io_wr(DC_CMD, 8'h80);
        cyc(2);
        chk({6'h00, bitclk_int_sel, bitclk_out}, 8'h00);
        // The sync char, a reset command, then an async mode word.
        io_wr(DC_CMD, 8'h00);
        io_wr(DC_CMD, 8'h40);
        io_wr(DC_CMD, 8'h02);
        cyc(2);
        chk({7'h00, bitclk_int_sel}, 8'h01);
        // Without the strap the board must not make the clock.
        xcvr_pins.async_strap = 1'b0;
        cyc(4);
        chk({6'h00, bitclk_int_sel, bitclk_out}, 8'h00);
        $display("t_xcvr done");
    endtask

    // Cuts a hang short well after the tests should have finished.
    initial begin
        #500000;
        mismatches++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        test_done();
    end

    // Main sequence; reset rises after time zero so every flop sees it.
    initial begin
        mismatches = 0;
        compares = 0;
        rst = 1'b0;
        ce = 1'b1;
        io = '0;
        xcvr_pins = '0;
        modem_want = '0;
        #1;
        rst = 1'b1;
        cyc(2);
        t_power_on();
        t_config();
        t_tx_enable();
        t_rx_sync();
        t_modem();
        t_xcvr();
        test_done();
    end
endmodule
